// ### core/wake_smi_pkg.sv
package wake_smi_pkg;

   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_WAKE_EN_FOUR = 6'h0D;
   localparam logic [5:0] IDX_WAKE_EN_FIVE = 6'h0E;
   localparam logic [5:0] IDX_RSVD_ZERO = 6'h0F;
   localparam logic [5:0] IDX_SM_STATUS_ONE = 6'h10;
   localparam logic [5:0] IDX_SM_STATUS_TWO = 6'h11;
   localparam logic [5:0] IDX_SM_STATUS_THREE = 6'h12;
   localparam logic [5:0] IDX_SM_STATUS_FOUR = 6'h13;
   localparam logic [5:0] IDX_IRQ_STATUS = 6'h20;
   localparam logic [5:0] IDX_IRQ_MASK = 6'h21;

   // Reset values
   localparam logic [7:0] RST_WAKE_EN = 8'h00;
   localparam logic [7:0] RST_SM_STATUS_ONE = 8'h02;
   localparam logic [7:0] RST_SM_STATUS = 8'h00;
   localparam logic [3:0] RST_IRQ = 4'h0;

   // First status register fields
   localparam int STS1_PARALLEL = 1;
   localparam int STS1_SECOND_SERIAL = 2;
   localparam int STS1_FIRST_SERIAL = 3;
   localparam int STS1_FLOPPY = 4;
   localparam int STS1_MIDI = 5;
   localparam int STS1_WATCHDOG = 7;

   // Second status register fields
   localparam int STS2_MOUSE = 0;
   localparam int STS2_KEYBOARD = 1;
   localparam int STS2_INFRARED = 2;
   localparam int STS2_KBC_PORT = 4;

   // Live bits of the clear-on-one registers (bit 3 of three reserved)
   localparam logic [7:0] STS3_LIVE_MASK = 8'hF7;
   localparam logic [7:0] STS4_LIVE_MASK = 8'hFF;

   // Interrupt status and mask fields
   localparam int IRQ_WIDTH = 4;
   localparam int IRQ_GPI_THREE = 0;
   localparam int IRQ_GPI_FOUR = 1;
   localparam int IRQ_INFRARED = 2;
   localparam int IRQ_WAKE = 3;

   // APB request from the master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   // Interrupt and line levels of the peripheral units
   typedef struct packed {
      logic parallel_active;
      logic printer_ack_in_n;
      logic second_serial_irq_flag;
      logic first_serial_irq_flag;
      logic floppy_irq_flag;
      logic midi_port_irq_flag;
      logic watchdog_expiry_flag;
      logic mouse_irq_flag;
      logic keyboard_irq_flag;
      logic kbc_port_line_flag;
   } unit_flags_t;

   // Infrared receive selection, sampled after the pin multiplexer
   typedef struct packed {
      logic ir_select_infrared;
      logic second_serial_receive_in;
      logic infrared_receive_in;
   } ir_lines_t;

endpackage

// ### core/sticky_bits.sv
`timescale 1ns/1ns
`default_nettype none

// Sticky flags: a set in the clear cycle keeps the flag
module sticky_bits #(
   parameter int W = 8
)(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Set and clear vectors
   input wire logic [W-1:0] set,
   input wire logic [W-1:0] clear,
   // Flag state
   output logic [W-1:0] q
);

   genvar i;

   // One flop per flag, set beats clear
   generate
      for (i = 0; i < W; i = i + 1)
      begin : g_bit
         always_ff @(posedge ref_clk or negedge rstn)
         begin
            if (!rstn)
               q[i] <= 1'b0;
            else
               q[i] <= set[i] | (q[i] & ~clear[i]);
         end
      end
   endgenerate

endmodule

`default_nettype wire

// ### core/wake_smi_regs.sv
// Overview of operation
// - Wake out when enable, status, global set
// - Disabled source never drives wake output
// - Wake enables clear only on standby reset
// - Wake enable four at 0D, mixed inputs
// - Wake enable five at 0E, inputs 50-57
// - Offset 0F reads zero always
// - Status one defaults 0x02, bit1 forced
// - Status one mirrors units, no write clear
// - Parallel flag high until active, then ack
// - Status one at 10, fixed unit map
// - Status two at 11, source-cleared bits
// - Infrared transition sets bit2, read clears
// - Status three at 12, write one clears
// - Status four at 13, write one clears
`timescale 1ns/1ns
`default_nettype none

module wake_smi_regs (
   // Clock and standby-supply reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Resets that leave the wake enables alone
   input wire logic main_supply_por,
   input wire logic hard_reset,
   input wire logic soft_reset,
   // APB slave
   input wire wake_smi_pkg::apb_req_t apb_req,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Wake sources
   input wire logic global_wake_enable,
   input wire logic [7:0] wake_status_four,
   input wire logic [7:0] wake_status_five,
   output logic wake_event_out_n,
   // Peripheral unit flags and infrared lines
   input wire wake_smi_pkg::unit_flags_t unit_flags,
   input wire wake_smi_pkg::ir_lines_t ir_lines,
   // General-purpose input events, one bit per status bit
   input wire logic [7:0] gpi_event_three,
   input wire logic [7:0] gpi_event_four,
   // Block interrupt
   output logic irq
);
   import wake_smi_pkg::*;

   // Index match used by every register decode
   function automatic logic at_index(input logic [7:0] addr,
                                     input logic [5:0] idx);
      at_index = (addr[7:2] == idx);
   endfunction

   // Registers
   logic [7:0] wake_enable_four;
   logic [7:0] wake_enable_five;
   logic [7:0] sysmgmt_status_one;
   logic [7:0] sysmgmt_status_two_live;
   logic [7:0] sysmgmt_status_three;
   logic [7:0] sysmgmt_status_four;
   logic [IRQ_WIDTH-1:0] irq_status;
   logic [IRQ_WIDTH-1:0] irq_mask;
   logic infrared_activity_flag;

   // Internal state
   logic ir_line_prev;
   logic ir_line_seen;
   logic wake_prev_n;

   // Bus phase decode
   wire setup_phase = apb_req.psel & ~apb_req.penable;
   wire access_done = apb_req.psel & apb_req.penable & pready;
   wire wr_done = access_done & apb_req.pwrite;
   wire rd_done = access_done & ~apb_req.pwrite;
   wire [7:0] wdata = apb_req.pwdata[7:0];

   // Register hits
   wire hit_en_four = at_index(apb_req.paddr, IDX_WAKE_EN_FOUR);
   wire hit_en_five = at_index(apb_req.paddr, IDX_WAKE_EN_FIVE);
   wire hit_rsvd = at_index(apb_req.paddr, IDX_RSVD_ZERO);
   wire hit_sts_one = at_index(apb_req.paddr, IDX_SM_STATUS_ONE);
   wire hit_sts_two = at_index(apb_req.paddr, IDX_SM_STATUS_TWO);
   wire hit_sts_three = at_index(apb_req.paddr, IDX_SM_STATUS_THREE);
   wire hit_sts_four = at_index(apb_req.paddr, IDX_SM_STATUS_FOUR);
   wire hit_irq_sts = at_index(apb_req.paddr, IDX_IRQ_STATUS);
   wire hit_irq_mask = at_index(apb_req.paddr, IDX_IRQ_MASK);
   wire hit_any = hit_en_four | hit_en_five | hit_rsvd | hit_sts_one |
                  hit_sts_two | hit_sts_three | hit_sts_four |
                  hit_irq_sts | hit_irq_mask;

   // Misaligned addresses count as unmapped
   wire addr_ok = hit_any & (apb_req.paddr[1:0] == 2'b00);

   // Write strobes
   wire wr_en_four = wr_done & addr_ok & hit_en_four;
   wire wr_en_five = wr_done & addr_ok & hit_en_five;
   wire wr_sts_three = wr_done & addr_ok & hit_sts_three;
   wire wr_sts_four = wr_done & addr_ok & hit_sts_four;
   wire wr_irq_sts = wr_done & addr_ok & hit_irq_sts;
   wire wr_irq_mask = wr_done & addr_ok & hit_irq_mask;

   // Status two read completion clears the infrared bit
   wire rd_sts_two = rd_done & addr_ok & hit_sts_two;

   // Any of the supply-side resets that the enables ride through
   wire other_reset = main_supply_por | hard_reset | soft_reset;

   // Wake output gating per source
   wire [7:0] wake_hits_four = wake_enable_four & wake_status_four;
   wire [7:0] wake_hits_five = wake_enable_five & wake_status_five;
   wire wake_any = |{wake_hits_four, wake_hits_five};
   wire next_wake_out_n = ~(wake_any & global_wake_enable);

   // Parallel flag: held high until the port is activated
   wire parallel_flag = ~unit_flags.parallel_active |
                        unit_flags.printer_ack_in_n;

   // Live mirror of the first status register
   wire [7:0] next_status_one;
   assign next_status_one[0] = 1'b0;
   assign next_status_one[STS1_PARALLEL] = parallel_flag | other_reset;
   assign next_status_one[STS1_SECOND_SERIAL] =
      unit_flags.second_serial_irq_flag;
   assign next_status_one[STS1_FIRST_SERIAL] =
      unit_flags.first_serial_irq_flag;
   assign next_status_one[STS1_FLOPPY] = unit_flags.floppy_irq_flag;
   assign next_status_one[STS1_MIDI] = unit_flags.midi_port_irq_flag;
   assign next_status_one[6] = 1'b0;
   assign next_status_one[STS1_WATCHDOG] = unit_flags.watchdog_expiry_flag;

   // Source-cleared bits of the second status register
   wire [7:0] next_status_two_live;
   assign next_status_two_live[STS2_MOUSE] = unit_flags.mouse_irq_flag;
   assign next_status_two_live[STS2_KEYBOARD] = unit_flags.keyboard_irq_flag;
   assign next_status_two_live[STS2_INFRARED] = 1'b0;
   assign next_status_two_live[3] = 1'b0;
   assign next_status_two_live[STS2_KBC_PORT] = unit_flags.kbc_port_line_flag;
   assign next_status_two_live[7:5] = 3'h0;

   // Infrared line after the multiplexer
   wire ir_line = ir_lines.ir_select_infrared ? ir_lines.infrared_receive_in :
                  ir_lines.second_serial_receive_in;

   // The very first sample only primes the edge detector
   wire ir_toggle = ir_line_seen & (ir_line != ir_line_prev);

   // Combined second status register as software sees it
   wire [7:0] sysmgmt_status_two;
   assign sysmgmt_status_two = sysmgmt_status_two_live |
      {5'h00, infrared_activity_flag, 2'b00};

   // Clear-on-one status: events set, written ones clear
   wire [7:0] set_three = gpi_event_three & STS3_LIVE_MASK;
   wire [7:0] set_four = gpi_event_four & STS4_LIVE_MASK;
   wire [7:0] clr_three = wr_sts_three ? wdata : 8'h00;
   wire [7:0] clr_four = wr_sts_four ? wdata : 8'h00;

   // Block events for the interrupt status
   wire wake_rise = wake_prev_n & ~next_wake_out_n;
   wire [IRQ_WIDTH-1:0] irq_events;
   assign irq_events[IRQ_GPI_THREE] = |(set_three & ~sysmgmt_status_three);
   assign irq_events[IRQ_GPI_FOUR] = |(set_four & ~sysmgmt_status_four);
   assign irq_events[IRQ_INFRARED] = ir_toggle;
   assign irq_events[IRQ_WAKE] = wake_rise;
   wire [IRQ_WIDTH-1:0] irq_clear =
      wr_irq_sts ? wdata[IRQ_WIDTH-1:0] : {IRQ_WIDTH{1'b0}};

   // Level interrupt from any unmasked status bit
   wire next_irq = |(irq_status & irq_mask);

   // Read data selection; reserved slot and bits read zero
   wire [7:0] rd_byte =
      !addr_ok ? 8'h00 :
      hit_en_four ? wake_enable_four :
      hit_en_five ? wake_enable_five :
      hit_rsvd ? 8'h00 :
      hit_sts_one ? sysmgmt_status_one :
      hit_sts_two ? sysmgmt_status_two :
      hit_sts_three ? sysmgmt_status_three :
      hit_sts_four ? sysmgmt_status_four :
      hit_irq_sts ? {4'h0, irq_status} :
      {4'h0, irq_mask};

   // Answer one cycle after setup: no wait states
   wire next_pready = setup_phase;
   wire next_pslverr = setup_phase & ~addr_ok;
   wire [31:0] next_prdata = {24'h00_0000, rd_byte};

   // Ready pulses once per transfer, in its access cycle
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         pready <= 1'b0;
      else
         pready <= next_pready;
   end

   // Error rides with ready, so a bad index never hangs the master
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         pslverr <= 1'b0;
      else
         pslverr <= next_pslverr;
   end

   // Read data captured at setup; holds until the next setup
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         prdata <= 32'h0000_0000;
      else if (setup_phase)
         prdata <= next_prdata;
   end

   // Wake enables; only the standby reset reaches them
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         wake_enable_four <= RST_WAKE_EN;
      else if (wr_en_four)
         wake_enable_four <= wdata;
   end

   // Fifth enable, same reset domain so armed wakes survive
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         wake_enable_five <= RST_WAKE_EN;
      else if (wr_en_five)
         wake_enable_five <= wdata;
   end

   // Status one mirrors its units; writes never touch it
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         sysmgmt_status_one <= RST_SM_STATUS_ONE;
      else
         sysmgmt_status_one <= next_status_one;
   end

   // Source-cleared part of status two, one edge behind like status one
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         sysmgmt_status_two_live <= RST_SM_STATUS;
      else
         sysmgmt_status_two_live <= next_status_two_live;
   end

   // Edge history; the seen bit keeps reset from faking a toggle
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ir_line_prev <= 1'b0;
         ir_line_seen <= 1'b0;
      end
      else
      begin
         ir_line_prev <= ir_line;
         ir_line_seen <= 1'b1;
      end
   end

   // Infrared activity: a transition wins over a clearing read
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         infrared_activity_flag <= 1'b0;
      else if (ir_toggle)
         infrared_activity_flag <= 1'b1;
      else if (rd_sts_two)
         infrared_activity_flag <= 1'b0;
   end

   // Third status register, bit 3 never latches
   sticky_bits #(
      .W(8)
   ) u_status_three (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .set(set_three),
      .clear(clr_three),
      .q(sysmgmt_status_three)
   );

   // Fourth status register
   sticky_bits #(
      .W(8)
   ) u_status_four (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .set(set_four),
      .clear(clr_four),
      .q(sysmgmt_status_four)
   );

   // Block interrupt status, cleared by writing one
   sticky_bits #(
      .W(IRQ_WIDTH)
   ) u_irq_status (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .set(irq_events),
      .clear(irq_clear),
      .q(irq_status)
   );

   // Mask register; a masked event still latches
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         irq_mask <= RST_IRQ;
      else if (wr_irq_mask)
         irq_mask <= wdata[IRQ_WIDTH-1:0];
   end

   // Wake output from a flop so the pin never glitches; idles high
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         wake_event_out_n <= 1'b1;
      else
         wake_event_out_n <= next_wake_out_n;
   end

   // Previous wake level, for the wake-asserting event
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         wake_prev_n <= 1'b1;
      else
         wake_prev_n <= next_wake_out_n;
   end

   // Level interrupt, one edge behind status and mask
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         irq <= 1'b0;
      else
         irq <= next_irq;
   end

endmodule

`default_nettype wire

// ### tb/wake_smi_regs_props.sv
`timescale 1ns/1ns
`default_nettype none

module wake_smi_regs_props (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Other resets
   input wire logic main_supply_por,
   input wire logic hard_reset,
   input wire logic soft_reset,
   // Bus
   input wire wake_smi_pkg::apb_req_t apb_req,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Wake and events
   input wire logic global_wake_enable,
   input wire logic [7:0] wake_status_four,
   input wire logic [7:0] wake_status_five,
   input wire logic wake_event_out_n,
   input wire wake_smi_pkg::unit_flags_t unit_flags,
   input wire wake_smi_pkg::ir_lines_t ir_lines,
   input wire logic [7:0] gpi_event_three,
   input wire logic [7:0] gpi_event_four,
   input wire logic irq
);
   import wake_smi_pkg::*;
   unit_flags_t fq;
   logic [1:0] calm;
   wire logic rd_ok = pready && !apb_req.pwrite;
   wire logic rd1 = rd_ok && apb_req.paddr == 8'h40;
   wire logic rd2 = rd_ok && apb_req.paddr == 8'h44;
   wire logic rd3 = rd_ok && apb_req.paddr == 8'h48;
   wire logic forced = main_supply_por || hard_reset || soft_reset;

   // Flags still for three edges, so the lagging mirror has caught up
   always_ff @(posedge ref_clk or negedge rstn)
      if (!rstn)
      begin
         fq <= '0;
         calm <= 2'h0;
      end
      else
      begin
         fq <= unit_flags;
         calm <= (fq != unit_flags) ? 2'h0 : calm + {1'b0, calm != 2'h3};
      end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);

   a_wake_global: assert property (
      !global_wake_enable |=> wake_event_out_n)
      else $error("wake low while globally disabled");
   a_wake_quiet: assert property (
      wake_status_four == 8'h00 && wake_status_five == 8'h00
      |=> wake_event_out_n)
      else $error("wake low with no status set");
   a_rsvd_zero: assert property (
      rd_ok && apb_req.paddr == 8'h3C |-> prdata == 32'h0)
      else $error("reserved slot read nonzero");
   a_one_rsvd: assert property (
      rd1 |-> {prdata[31:8], prdata[6], prdata[0]} == 26'h0)
      else $error("status one reserved bits set");
   a_one_mirror: assert property (
      rd1 && calm == 2'h3 |-> prdata[7:2] == {fq.watchdog_expiry_flag,
      1'b0, fq.midi_port_irq_flag, fq.floppy_irq_flag,
      fq.first_serial_irq_flag, fq.second_serial_irq_flag})
      else $error("status one does not mirror units");
   a_parallel_idle: assert property (
      rd1 && calm == 2'h3 && !fq.parallel_active |-> prdata[1])
      else $error("parallel flag low while inactive");
   a_two_mirror: assert property (
      rd2 && calm == 2'h3 |-> {prdata[7:3], prdata[1:0]} == {3'h0,
      fq.kbc_port_line_flag, 1'b0, fq.keyboard_irq_flag, fq.mouse_irq_flag})
      else $error("status two does not mirror units");
   a_three_rsvd: assert property (
      rd3 |-> prdata[3] == 1'b0)
      else $error("status three reserved bit set");
   a_reset_force: assert property (
      forced [*2] ##1 rd1 |-> prdata[1])
      else $error("parallel flag not forced by reset");

   c_wake: cover property (!wake_event_out_n);
   c_irq: cover property (irq);
   c_err: cover property (pready && pslverr);
endmodule

bind wake_smi_regs wake_smi_regs_props u_props (.*);

`default_nettype wire

// ### tb/tb_wake_smi_regs.sv
`timescale 1ns/1ns
`default_nettype none
// Compare and count
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

module tb_wake_smi_regs;
   import wake_smi_pkg::*;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic [2:0] rst3 = 3'h0;
   apb_req_t req = '0;
   unit_flags_t uf = '0;
   ir_lines_t ir = '0;
   logic gwe = 1'b0;
   logic [7:0] ws4 = 8'h00, ws5 = 8'h00, ev3 = 8'h00, ev4 = 8'h00;
   logic [31:0] prdata;
   logic pready, pslverr, wake_n, irq;
   logic [32:0] q[$];
   logic [32:0] e;
   logic [15:0] m;
   logic [7:0] r;
   int fails = 0;
   int comparisons = 0;

   always #50 ref_clk = ~ref_clk;

   wake_smi_regs dut (.ref_clk(ref_clk), .rstn(rstn),
      .main_supply_por(rst3[0]), .hard_reset(rst3[1]), .soft_reset(rst3[2]),
      .apb_req(req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .global_wake_enable(gwe), .wake_status_four(ws4),
      .wake_status_five(ws5), .wake_event_out_n(wake_n), .unit_flags(uf),
      .ir_lines(ir), .gpi_event_three(ev3), .gpi_event_four(ev4), .irq(irq));

   // Each finished transfer is checked against the oldest note
   always @(posedge ref_clk)
      if (req.psel && req.penable && pready === 1'b1)
      begin
         e = q.pop_front();
         if (req.pwrite)
            `CHK(pslverr, e[32])
         else
            `CHK({pslverr, prdata}, e)
      end

   // Request held until pready is seen; only the watchdog ends a wait
   task automatic xfer(logic w, logic [7:0] a, logic [7:0] d, logic [32:0] x);
      q.push_back(x);
      @(posedge ref_clk);
      req <= '{1'b1, 1'b0, w, a, {24'h0, d}};
      @(posedge ref_clk);
      req.penable <= 1'b1;
      do
         @(posedge ref_clk);
      while (pready !== 1'b1);
      req <= '0;
   endtask

   task automatic rd(logic [5:0] x, logic [7:0] d);
      xfer(1'b0, {x, 2'b00}, 8'h00, {25'h0, d});
   endtask

   task automatic wr(logic [5:0] x, logic [7:0] d);
      xfer(1'b1, {x, 2'b00}, d, 33'h0);
   endtask

   task automatic tick(int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task automatic stop_test;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Watchdog well beyond the few hundred cycles needed
   initial
   begin
      #1000000;
      fails++;
      stop_test();
   end

   initial
   begin
      void'($urandom(32'h848c9809));
      tick(3);
      rstn <= 1'b1;
      // Reset contents, bad addresses and read-only places
      rd(IDX_WAKE_EN_FOUR, 8'h00);
      rd(IDX_WAKE_EN_FIVE, 8'h00);
      rd(IDX_SM_STATUS_ONE, 8'h02);
      rd(IDX_SM_STATUS_THREE, 8'h00);
      rd(IDX_SM_STATUS_FOUR, 8'h00);
      xfer(1'b0, 8'hC0, 8'h00, {1'b1, 32'h0});
      xfer(1'b1, 8'h35, 8'hFF, {1'b1, 32'h0});
      rd(IDX_WAKE_EN_FOUR, 8'h00);
      wr(IDX_RSVD_ZERO, 8'hFF);
      rd(IDX_RSVD_ZERO, 8'h00);
      wr(IDX_SM_STATUS_ONE, 8'hFF);
      rd(IDX_SM_STATUS_ONE, 8'h02);
      // Enables survive the resets that only force the parallel flag
      r = 8'($urandom);
      wr(IDX_WAKE_EN_FOUR, r);
      wr(IDX_WAKE_EN_FIVE, ~r);
      uf <= '{parallel_active: 1'b1, default: 1'b0};
      for (int i = 0; i < 3; i++)
      begin
         rst3 <= 3'h1 << i;
         rd(IDX_SM_STATUS_ONE, 8'h02);
         rst3 <= 3'h0;
         rd(IDX_SM_STATUS_ONE, 8'h00);
      end
      rd(IDX_WAKE_EN_FOUR, r);
      rd(IDX_WAKE_EN_FIVE, ~r);
      // Each enable bit gates only its own status bit
      gwe <= 1'b1;
      for (int i = 0; i < 16; i++)
      begin
         m = 16'h1 << i;
         wr(IDX_WAKE_EN_FOUR, m[7:0]);
         wr(IDX_WAKE_EN_FIVE, m[15:8]);
         {ws5, ws4} <= m;
         tick(2);
         `CHK(wake_n, 1'b0)
         {ws5, ws4} <= ~m;
         tick(2);
         `CHK(wake_n, 1'b1)
      end
      gwe <= 1'b0;
      {ws5, ws4} <= 16'hFFFF;
      tick(2);
      `CHK(wake_n, 1'b1)
      // Status one and two follow random unit flags
      for (int i = 0; i < 4; i++)
      begin
         uf <= 10'($urandom);
         tick(1);
         rd(IDX_SM_STATUS_ONE, {uf.watchdog_expiry_flag, 1'b0,
            uf.midi_port_irq_flag, uf.floppy_irq_flag,
            uf.first_serial_irq_flag, uf.second_serial_irq_flag,
            ~uf.parallel_active | uf.printer_ack_in_n, 1'b0});
         rd(IDX_SM_STATUS_TWO, {3'h0, uf.kbc_port_line_flag, 2'h0,
            uf.keyboard_irq_flag, uf.mouse_irq_flag});
      end
      // Only the selected receive line sets the activity bit
      uf <= '0;
      ir <= 3'h4;
      rd(IDX_SM_STATUS_TWO, 8'h00);
      ir <= 3'h5;
      rd(IDX_SM_STATUS_TWO, 8'h04);
      rd(IDX_SM_STATUS_TWO, 8'h00);
      ir <= 3'h7;
      rd(IDX_SM_STATUS_TWO, 8'h00);
      ir <= 3'h3;
      rd(IDX_SM_STATUS_TWO, 8'h00);
      ir <= 3'h1;
      rd(IDX_SM_STATUS_TWO, 8'h04);
      // Sticky latches hold until a one is written back
      wr(IDX_IRQ_STATUS, 8'h0F);
      wr(IDX_IRQ_MASK, 8'h01);
      r = 8'($urandom) | 8'h01;
      ev3 <= r;
      tick(1);
      ev3 <= 8'h00;
      tick(2);
      `CHK(irq, 1'b1)
      rd(IDX_SM_STATUS_THREE, r & 8'hF7);
      wr(IDX_SM_STATUS_THREE, 8'h00);
      rd(IDX_SM_STATUS_THREE, r & 8'hF7);
      wr(IDX_SM_STATUS_THREE, r & 8'h0F);
      rd(IDX_SM_STATUS_THREE, r & 8'hF0);
      wr(IDX_IRQ_STATUS, 8'h01);
      tick(2);
      `CHK(irq, 1'b0)
      // A masked event stays pending until unmasked
      wr(IDX_IRQ_MASK, 8'h00);
      ev3 <= 8'h01;
      tick(1);
      ev3 <= 8'h00;
      tick(2);
      `CHK(irq, 1'b0)
      wr(IDX_IRQ_MASK, 8'h01);
      tick(2);
      `CHK(irq, 1'b1)
      rd(IDX_IRQ_STATUS, 8'h01);
      r = 8'($urandom);
      ev4 <= r;
      tick(1);
      ev4 <= 8'h00;
      rd(IDX_SM_STATUS_FOUR, r);
      wr(IDX_SM_STATUS_FOUR, 8'hFF);
      rd(IDX_SM_STATUS_FOUR, 8'h00);
      // Standby reset in mid-run clears the enables
      wr(IDX_WAKE_EN_FOUR, 8'hA5);
      rstn <= 1'b0;
      tick(2);
      rstn <= 1'b1;
      rd(IDX_WAKE_EN_FOUR, 8'h00);
      rd(IDX_WAKE_EN_FIVE, 8'h00);
      stop_test();
   end
endmodule

`default_nettype wire
